// ===== rxaf_filter.sv
// rxaf_filter: destination-address filter of the receive path.
// assumes the mac receive datapath shares mclk_in and feeds one address bit
// per valid cycle, first received bit first, after a one-cycle frame start.
`timescale 1ns/10ps

module rxaf_filter
  import rxaf_pkg::*;
(
  // clock and reset
  input  wire logic              mclk_in,
  input  wire logic              rstn_in,
  // register port
  input  wire logic [ADDR_W-1:0] reg_addr_in,
  input  wire logic [DATA_W-1:0] reg_wdata_in,
  input  wire logic              reg_wr_in,
  input  wire logic              reg_rd_in,
  output logic      [DATA_W-1:0] reg_rdata_out,
  // destination address bits from the receive datapath
  input  wire logic              frame_start_in,
  input  wire logic              dest_addr_valid_in,
  input  wire logic              dest_addr_bit_in,
  // verdict
  output rxaf_match_t            match_out,
  output logic                   match_valid_out,
  output logic [HASH_BITS-1:0]   hash_index_out
);

  // registers
  logic [7:0]        station_addr_bytes [DA_BYTES];
  logic [7:0]        hash_filter_bytes  [HASH_REGS];
  rxaf_cfg_t         rx_cfg_r;
  logic [7:0]        rdata_r;

  // frame tracking
  rxaf_state_t       state_r;
  rxaf_state_t       state_nxt;
  logic [5:0]        bit_cnt_r;
  logic [2:0]        byte_idx;
  logic [2:0]        bit_idx;
  logic              last_bit;
  logic              take_bit;

  // filter state
  logic [CRC_W-1:0]  crc_r;
  logic [CRC_W-1:0]  crc_nxt;
  logic              mcast_r;
  logic              byte_mismatch_r;
  logic              all_ones_r;
  logic              expect_bit;
  logic              bit_differs;

  // verdict
  logic [HASH_BITS-1:0] hash_r;
  logic [HASH_BITS-1:0] hash_nxt;
  logic              filter_bit;
  rxaf_match_t       match_r;
  rxaf_match_t       match_nxt;
  logic              match_valid_r;
  logic              done_r;

  //--------------------------------------------------------------------------
  // register writes
  //--------------------------------------------------------------------------

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < DA_BYTES; i++) begin
        station_addr_bytes[i] <= STATION_RST;
      end
    end else if (reg_wr_in && reg_addr_in >= OFS_STATION0 && reg_addr_in <= OFS_STATION5) begin
      station_addr_bytes[reg_addr_in[2:0]] <= reg_wdata_in;
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      for (int i = 0; i < HASH_REGS; i++) begin
        hash_filter_bytes[i] <= HASH_RST;
      end
    end else if (reg_wr_in && reg_addr_in >= OFS_HASH0 && reg_addr_in <= OFS_HASH7) begin
      hash_filter_bytes[reg_addr_in[2:0]] <= reg_wdata_in;
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rx_cfg_r <= rxaf_cfg_t'(RX_CFG_RST[2:0]);
    end else if (reg_wr_in && reg_addr_in == OFS_RX_CFG) begin
      // only the accept settings are stored; the other bits read back as zero
      rx_cfg_r.accept_broadcast_cfg <= reg_wdata_in[CFG_AB_BIT];
      rx_cfg_r.accept_multicast_cfg <= reg_wdata_in[CFG_AM_BIT];
      rx_cfg_r.promiscuous_cfg      <= reg_wdata_in[CFG_PRO_BIT];
    end
  end

  //--------------------------------------------------------------------------
  // register reads: data stand in the cycle after the strobe only
  //--------------------------------------------------------------------------

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rdata_r <= 8'h00;
    end else if (reg_rd_in) begin
      rdata_r <= 8'h00;
      if (reg_addr_in >= OFS_STATION0 && reg_addr_in <= OFS_STATION5) begin
        rdata_r <= station_addr_bytes[reg_addr_in[2:0]];
      end else if (reg_addr_in >= OFS_HASH0 && reg_addr_in <= OFS_HASH7) begin
        rdata_r <= hash_filter_bytes[reg_addr_in[2:0]];
      end else if (reg_addr_in == OFS_RX_CFG) begin
        rdata_r[CFG_AB_BIT]  <= rx_cfg_r.accept_broadcast_cfg;
        rdata_r[CFG_AM_BIT]  <= rx_cfg_r.accept_multicast_cfg;
        rdata_r[CFG_PRO_BIT] <= rx_cfg_r.promiscuous_cfg;
      end else if (reg_addr_in == OFS_STATUS) begin
        // a snapshot of the last verdict; it clears when the next frame starts
        rdata_r[ST_UNI_BIT]   <= match_r.unicast_hit;
        rdata_r[ST_MUL_BIT]   <= match_r.multicast_hit;
        rdata_r[ST_BRO_BIT]   <= match_r.broadcast_hit;
        rdata_r[ST_AGG_BIT]   <= match_r.aggregate_hit;
        rdata_r[ST_MCAST_BIT] <= mcast_r;
        rdata_r[ST_DONE_BIT]  <= done_r;
      end
    end else begin
      // read data are valid for one cycle, then fall back to zero
      rdata_r <= 8'h00;
    end
  end

  assign reg_rdata_out = rdata_r;

  //--------------------------------------------------------------------------
  // frame sequencing
  //--------------------------------------------------------------------------

  // a start pulse wins over a bit in the same cycle, so a restart never counts it
  assign take_bit = (state_r == RXAF_ADDR) && dest_addr_valid_in && !frame_start_in;
  assign last_bit = take_bit && (bit_cnt_r == 6'(DA_BITS - 1));

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      RXAF_IDLE: begin
        if (frame_start_in) begin
          state_nxt = RXAF_ADDR;
        end
      end
      RXAF_ADDR: begin
        if (frame_start_in) begin
          state_nxt = RXAF_ADDR;
        end else if (last_bit) begin
          state_nxt = RXAF_HOLD;
        end
      end
      RXAF_HOLD: begin
        // bits past the destination field are not filtered
        if (frame_start_in) begin
          state_nxt = RXAF_ADDR;
        end
      end
      default: begin
        // the fourth code of the state register is unused; recover to idle
        state_nxt = RXAF_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      state_r <= RXAF_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // received order, bit 0 first
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bit_cnt_r <= 6'h00;
    end else if (frame_start_in) begin
      bit_cnt_r <= 6'h00;
    end else if (take_bit) begin
      bit_cnt_r <= bit_cnt_r + 6'h01;
    end
  end

  // destination bit 8k+n lands in station byte k, bit n
  assign byte_idx = bit_cnt_r[5:3];
  assign bit_idx  = bit_cnt_r[2:0];

  //--------------------------------------------------------------------------
  // unicast compare
  //--------------------------------------------------------------------------

  // a bit-serial compare gives the same answer as a byte-wide one and
  // needs no staging register for the incoming byte
  always_comb begin
    expect_bit = 1'b0;
    if (byte_idx < 3'(DA_BYTES)) begin
      expect_bit = station_addr_bytes[byte_idx][bit_idx];
    end
  end

  assign bit_differs = dest_addr_bit_in ^ expect_bit;

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      byte_mismatch_r <= 1'b0;
    end else if (frame_start_in) begin
      byte_mismatch_r <= 1'b0;
    end else if (take_bit && bit_differs) begin
      byte_mismatch_r <= 1'b1;
    end
  end

  //--------------------------------------------------------------------------
  // broadcast and multicast classification
  //--------------------------------------------------------------------------

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      all_ones_r <= 1'b0;
    end else if (frame_start_in) begin
      all_ones_r <= 1'b1;
    end else if (take_bit && !dest_addr_bit_in) begin
      all_ones_r <= 1'b0;
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mcast_r <= 1'b0;
    end else if (frame_start_in) begin
      mcast_r <= 1'b0;
    end else if (take_bit && bit_cnt_r == 6'h00) begin
      mcast_r <= dest_addr_bit_in;
    end
  end

  //--------------------------------------------------------------------------
  // crc hash
  //--------------------------------------------------------------------------

  always_comb begin
    crc_nxt = {crc_r[CRC_W-2:0], 1'b0};
    if (crc_r[CRC_W-1] ^ dest_addr_bit_in) begin
      crc_nxt = crc_nxt ^ CRC_POLY;
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      crc_r <= CRC_INIT;
    end else if (frame_start_in) begin
      crc_r <= CRC_INIT;
    end else if (take_bit) begin
      crc_r <= crc_nxt;
    end
  end

  // the top bits are taken from the value that includes the last bit
  // the index is then held until the next complete field, so a slow consumer can take it
  assign hash_nxt = crc_nxt[CRC_W-1:CRC_W-HASH_BITS];

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      hash_r <= '0;
    end else if (last_bit) begin
      hash_r <= hash_nxt;
    end
  end

  // with all 64 bits set every index hits, so every multicast sets multicast_hit
  assign filter_bit = hash_filter_bytes[hash_nxt[5:3]][hash_nxt[2:0]];

  //--------------------------------------------------------------------------
  // verdict
  //--------------------------------------------------------------------------

  always_comb begin
    logic first_one;
    logic ones;
    logic differs;
    first_one = 1'b0;
    ones      = 1'b0;
    differs   = 1'b0;
    // the last bit is still in flight, so fold it in here
    first_one = mcast_r;
    ones      = all_ones_r && dest_addr_bit_in;
    differs   = byte_mismatch_r || bit_differs;
    match_nxt.unicast_hit   = !differs;
    match_nxt.multicast_hit = first_one && filter_bit;
    match_nxt.broadcast_hit = ones;
    match_nxt.aggregate_hit = rx_cfg_r.promiscuous_cfg
                           || match_nxt.unicast_hit
                           || (match_nxt.multicast_hit && rx_cfg_r.accept_multicast_cfg)
                           || (match_nxt.broadcast_hit && rx_cfg_r.accept_broadcast_cfg);
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      match_r <= '0;
    end else if (frame_start_in) begin
      match_r <= '0;
    end else if (last_bit) begin
      match_r <= match_nxt;
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      match_valid_r <= 1'b0;
    end else begin
      // a restart before the last bit leaves no pulse for the cut frame
      match_valid_r <= last_bit;
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      done_r <= 1'b0;
    end else if (frame_start_in) begin
      done_r <= 1'b0;
    end else if (last_bit) begin
      // status bit: set once all 48 bits of this frame are in
      done_r <= 1'b1;
    end
  end

  assign match_out       = match_r;
  assign match_valid_out = match_valid_r;
  assign hash_index_out  = hash_r;

endmodule

// ===== rxaf_pkg.sv
// rxaf_pkg: constants and carrier types of the receive address filter.
// assumes a 20 MHz controller clock and a serial destination-address feed.
package rxaf_pkg;

  // register bus geometry
  localparam int ADDR_W = 5;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [4:0] OFS_STATION0 = 5'h00;
  localparam logic [4:0] OFS_STATION5 = 5'h05;
  localparam logic [4:0] OFS_HASH0    = 5'h08;
  localparam logic [4:0] OFS_HASH7    = 5'h0f;
  localparam logic [4:0] OFS_RX_CFG   = 5'h10;
  localparam logic [4:0] OFS_STATUS   = 5'h11;

  // reset values
  localparam logic [7:0] STATION_RST = 8'h00;
  localparam logic [7:0] HASH_RST    = 8'h00;
  localparam logic [7:0] RX_CFG_RST  = 8'h00;

  // receive configuration field positions
  localparam int CFG_AB_BIT  = 0;
  localparam int CFG_AM_BIT  = 1;
  localparam int CFG_PRO_BIT = 2;

  // status field positions
  localparam int ST_UNI_BIT  = 0;
  localparam int ST_MUL_BIT  = 1;
  localparam int ST_BRO_BIT  = 2;
  localparam int ST_AGG_BIT  = 3;
  localparam int ST_MCAST_BIT = 4;
  localparam int ST_DONE_BIT = 5;

  // destination address and hash
  localparam int DA_BITS   = 48;
  localparam int DA_BYTES  = 6;
  localparam int HASH_BITS = 6;
  localparam int HASH_REGS = 8;
  localparam int CRC_W     = 32;
  localparam logic [31:0] CRC_POLY = 32'h04c11db7;
  localparam logic [31:0] CRC_INIT = 32'hffffffff;

  // receive accept settings
  typedef struct packed {
    logic promiscuous_cfg;
    logic accept_multicast_cfg;
    logic accept_broadcast_cfg;
  } rxaf_cfg_t;

  // per-frame filter verdict
  typedef struct packed {
    logic unicast_hit;
    logic multicast_hit;
    logic broadcast_hit;
    logic aggregate_hit;
  } rxaf_match_t;

  typedef enum logic [1:0] {
    RXAF_IDLE,
    RXAF_ADDR,
    RXAF_HOLD
  } rxaf_state_t;

endpackage

// ===== rxaf_filter_assertions.sv
// rxaf_chk: port-level checks of the receive address filter.
// assumes it is bound to rxaf_filter and shares its single clock.
`timescale 1ns/10ps
module rxaf_chk
  import rxaf_pkg::*;
(
  // clock and reset
  input wire logic                 mclk_in,
  input wire logic                 rstn_in,
  // register read side
  input wire logic                 reg_rd_in,
  input wire logic [DATA_W-1:0]    reg_rdata_out,
  // bit feed and verdict
  input wire logic                 frame_start_in,
  input wire logic                 dest_addr_valid_in,
  input wire logic                 dest_addr_bit_in,
  input wire rxaf_match_t          match_out,
  input wire logic                 match_valid_out,
  input wire logic [HASH_BITS-1:0] hash_index_out
);
  logic [5:0]  cnt_r;
  logic        live_r;
  logic        first_r;
  logic        ones_r;
  logic [31:0] crc_r;
  logic        take;
  logic        last;
  assign take = dest_addr_valid_in && !frame_start_in && live_r;
  assign last = take && cnt_r == 6'h2f;
  // own crc so the hash is judged independently of the design's generator
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cnt_r <= 6'h00;
      live_r <= 1'b0;
      first_r <= 1'b0;
      ones_r <= 1'b0;
      crc_r <= CRC_INIT;
    end else if (frame_start_in) begin
      cnt_r <= 6'h00;
      live_r <= 1'b1;
      ones_r <= 1'b1;
      crc_r <= CRC_INIT;
    end else if (take) begin
      cnt_r <= cnt_r + 6'h01;
      live_r <= !last;
      if (cnt_r == 6'h00) first_r <= dest_addr_bit_in;
      ones_r <= ones_r & dest_addr_bit_in;
      crc_r <= {crc_r[30:0], 1'b0} ^ ((crc_r[31] ^ dest_addr_bit_in) ? CRC_POLY : 32'h0);
    end
  end
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (!rstn_in);
  a_hash_crc_top: assert property (match_valid_out |-> hash_index_out == crc_r[31:26])
    else $error("hash index wrong");
  a_bro_all_ones: assert property (match_valid_out |-> match_out.broadcast_hit == ones_r)
    else $error("broadcast flag wrong");
  a_mul_first_bit: assert property (match_valid_out && match_out.multicast_hit |-> first_r)
    else $error("multicast hit on group bit zero");
  a_agg_on_uni: assert property (match_valid_out && match_out.unicast_hit |-> match_out.aggregate_hit)
    else $error("unicast hit not accepted");
  a_done_after: assert property (last |=> match_valid_out)
    else $error("verdict late");
  a_no_stray_done: assert property (!last |=> !match_valid_out)
    else $error("verdict without 48 bits");
  a_clear_start: assert property (frame_start_in |=> match_out == 4'h0)
    else $error("match not cleared");
  a_match_hold: assert property (!frame_start_in && !last |=> $stable(match_out))
    else $error("match moved");
  a_hash_hold: assert property (!last |=> $stable(hash_index_out))
    else $error("hash moved");
  a_read_idle: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
    else $error("read data without read");
endmodule

bind rxaf_filter rxaf_chk chk_u (
  .mclk_in(mclk_in), .rstn_in(rstn_in), .reg_rd_in(reg_rd_in), .reg_rdata_out(reg_rdata_out),
  .frame_start_in(frame_start_in), .dest_addr_valid_in(dest_addr_valid_in),
  .dest_addr_bit_in(dest_addr_bit_in), .match_out(match_out),
  .match_valid_out(match_valid_out), .hash_index_out(hash_index_out));

// ===== rxaf_mac_model.sv
// rxaf_mac_model: receive datapath feeding destination bits one per valid cycle.
// assumes send() is called right after a rising edge of mclk_in.
`timescale 1ns/10ps
module rxaf_mac_model (
  // clock
  input wire logic mclk_in,
  // bit feed
  output logic     frame_start_out,
  output logic     dest_addr_valid_out,
  output logic     dest_addr_bit_out
);
  initial begin
    frame_start_out = 1'b0;
    dest_addr_valid_out = 1'b0;
    dest_addr_bit_out = 1'b0;
  end
  // slow mode leaves random gaps; idle bits are inverted so stale data never matches
  task automatic send(input logic [47:0] da, input bit slow);
    int i;
    i = 0;
    frame_start_out <= 1'b1;
    @(posedge mclk_in);
    frame_start_out <= 1'b0;
    while (i < 48) begin
      if (slow && $urandom_range(1) == 0) begin
        dest_addr_valid_out <= 1'b0;
        dest_addr_bit_out <= !dest_addr_bit_out;
      end else begin
        dest_addr_valid_out <= 1'b1;
        dest_addr_bit_out <= da[i];
        i++;
      end
      @(posedge mclk_in);
    end
    dest_addr_valid_out <= 1'b0;
    dest_addr_bit_out <= !da[47];
  endtask
endmodule

// ===== tb_top.sv
// tb_top: self-checking bench of the receive address filter.
// assumes the mac model drives the bit feed and the bench drives the registers.
`timescale 1ns/10ps
module tb_top;
  import rxaf_pkg::*;
  logic                 mclk_in;
  logic                 rstn_in;
  logic                 reg_wr_in;
  logic                 reg_rd_in;
  logic                 rd_d;
  logic [ADDR_W-1:0]    reg_addr_in;
  logic [DATA_W-1:0]    reg_wdata_in;
  logic [DATA_W-1:0]    reg_rdata_out;
  logic                 fs;
  logic                 dv;
  logic                 db;
  logic                 match_valid_out;
  rxaf_match_t          match_out;
  logic [HASH_BITS-1:0] hash_index_out;
  logic [47:0]          da;
  logic [47:0]          st;
  logic [7:0]           regs [32];
  logic [7:0]           rd_q [$];
  logic [9:0]           m_q [$];
  int                   num_errors;
  int                   checks;

  rxaf_mac_model mac_u (.mclk_in(mclk_in), .frame_start_out(fs), .dest_addr_valid_out(dv),
    .dest_addr_bit_out(db));
  rxaf_filter dut_u (.mclk_in(mclk_in), .rstn_in(rstn_in), .reg_addr_in(reg_addr_in),
    .reg_wdata_in(reg_wdata_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
    .reg_rdata_out(reg_rdata_out), .frame_start_in(fs), .dest_addr_valid_in(dv),
    .dest_addr_bit_in(db), .match_out(match_out), .match_valid_out(match_valid_out),
    .hash_index_out(hash_index_out));

  initial begin
    mclk_in = 1'b0;
    forever #25 mclk_in = ~mclk_in;
  end

  task automatic chk(input logic [9:0] seen, input logic [9:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // one bus cycle; strobes are always rewritten so back-to-back calls never double-drive
  task automatic bus(input bit w, input logic [4:0] a, input logic [7:0] d, input bit r);
    reg_wr_in <= w;
    reg_rd_in <= r;
    reg_addr_in <= a;
    reg_wdata_in <= d;
    if (r) rd_q.push_back(regs[a]);
    // only the three accept settings of the configuration register are kept
    if (w && a != 5'h06 && a != 5'h07 && a <= OFS_RX_CFG) regs[a] = (a == OFS_RX_CFG) ? (d & 8'h07) : d;
    @(posedge mclk_in);
  endtask

  task automatic frame(input logic [47:0] a, input bit slow);
    logic [31:0] c;
    logic        u;
    logic        mu;
    logic        b;
    logic        g;
    c = CRC_INIT;
    for (int i = 0; i < 48; i++) c = {c[30:0], 1'b0} ^ ((c[31] ^ a[i]) ? CRC_POLY : 32'h0);
    u = a == {regs[5], regs[4], regs[3], regs[2], regs[1], regs[0]};
    mu = a[0] & regs[8 + c[31:29]][c[28:26]];
    b = &a;
    g = regs[16][2] | u | (mu & regs[16][1]) | (b & regs[16][0]);
    m_q.push_back({u, mu, b, g, c[31:26]});
    regs[17] = {2'b00, 1'b1, a[0], g, b, mu, u};
    mac_u.send(a, slow);
  endtask

  always @(posedge mclk_in) begin
    rd_d <= reg_rd_in;
    if (rd_d) chk({2'b00, reg_rdata_out}, {2'b00, rd_q.pop_front()});
    if (match_valid_out === 1'b1) chk({match_out, hash_index_out}, m_q.pop_front());
  end

  task automatic end_sim;
    if (num_errors == 0 && checks > 0 && rd_q.size() == 0 && m_q.size() == 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial begin
    #1_000_000;
    num_errors++;
    end_sim();
  end

  initial begin
    rstn_in = 1'b0;
    reg_wr_in = 1'b0;
    reg_rd_in = 1'b0;
    rd_d = 1'b0;
    reg_addr_in = 5'h00;
    reg_wdata_in = 8'h00;
    foreach (regs[i]) regs[i] = 8'h00;
    void'($urandom(32'h2804));
    repeat (12) @(posedge mclk_in);
    rstn_in <= 1'b1;
    // reset values, unmapped places, refused status writes
    for (int a = 0; a < 20; a++) bus(0, a[4:0], 8'h00, 1);
    for (int a = 0; a < 20; a++) bus(1, a[4:0], 8'($urandom), 0);
    for (int a = 0; a < 20; a++) bus(0, a[4:0], 8'h00, 1);
    for (int k = 0; k < 40; k++) begin
      bus(1, OFS_RX_CFG, 8'(k % 8), 0);
      if (k == 30) for (int a = 8; a < 16; a++) bus(1, a[4:0], 8'hff, 0);
      bus(0, 5'h00, 8'h00, 0);
      st = {regs[5], regs[4], regs[3], regs[2], regs[1], regs[0]};
      case (k % 5)
        0: da = 48'({$urandom, $urandom});
        1: da = st;
        2: da = st ^ (48'h1 << (8 * ((k / 5) % 6) + 7));
        3: da = 48'hffff_ffff_ffff;
        default: da = {47'({$urandom, $urandom}), 1'b1};
      endcase
      frame(da, k[0]);
      bus(0, 5'h00, 8'h00, 0);
      bus(0, OFS_STATUS, 8'h00, 1);
      bus(0, 5'h00, 8'h00, 0);
    end
    repeat (3) @(posedge mclk_in);
    end_sim();
  end
endmodule
